//--- src/pps_sequencer.sv
// Pulse program sequencer core: program store, flow control, delay timer.
// Assumes the host logic writes the store and issues start/stop as pulses
// on core_clk; trigger and reset pins are asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Drive 24 outputs from current instruction pattern
// - Store holds up to 4096 instructions
// - Each instruction carries its own duration
// - Delay resolution is one clock period
// - Short form allows 32-bit delay counts
// - Long form allows 52-bit delay counts
// - Minimum instruction duration is five cycles
// - Branch, call, return, loop; eight-deep stacks
// - Loop counters are 20 bits wide
// - Resume eight cycles after trigger recognised
// - Trigger and reset active low, level-held
// - External trigger starts, external reset stops and returns to address 0
// - Run status visible on pins and host
// - Host loads program and starts, stops
module pps_sequencer
	import pps_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Host program load port
	input  wire logic        prog_we,
	input  wire logic [11:0] prog_addr,
	input  wire logic [23:0] prog_pattern,
	input  wire logic [2:0]  prog_op,
	input  wire logic [19:0] prog_data,
	input  wire logic        prog_long,
	input  wire logic [51:0] prog_delay,
	// Host commands
	input  wire logic        host_start,
	input  wire logic        host_stop,
	// External pins
	input  wire logic        trig_n,
	input  wire logic        hw_reset_n,
	// Outputs and status
	output logic      [23:0] chan_out,
	output logic             stat_running,
	output logic             stat_waiting,
	output logic             stat_stopped
);
	// Program store
	logic [23:0] mem_pattern [PPS_DEPTH];
	logic [2:0]  mem_op      [PPS_DEPTH];
	logic [19:0] mem_data    [PPS_DEPTH];
	logic [51:0] mem_delay   [PPS_DEPTH];

	logic [2:0]  trig_sync_reg;
	logic [2:0]  hrst_sync_reg;
	logic        trig_lvl_reg;
	logic        hrst_lvl_reg;
	pps_state_t  state_reg;
	logic [11:0] pc_reg;
	logic [51:0] dly_reg;
	logic [3:0]  lat_reg;
	logic [11:0] ret_stack_reg  [PPS_STACK_DEPTH];
	logic [11:0] loop_addr_reg  [PPS_STACK_DEPTH];
	logic [19:0] loop_cnt_reg   [PPS_STACK_DEPTH];
	logic [3:0]  rsp_reg;
	logic [3:0]  lsp_reg;
	logic [23:0] out_reg;

	// Assertion clock and reset for every property below
	default clocking pps_cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// Clamp programmed delays to the minimum supported length
	function automatic logic [51:0] clamp_delay(input logic [51:0] d);
		return (d < PPS_MIN_DELAY) ? PPS_MIN_DELAY : d;
	endfunction

	// Program store write; short form keeps only 32 delay bits
	always_ff @(posedge core_clk) begin
		if (prog_we) begin
			mem_pattern[prog_addr] <= prog_pattern;
			mem_op[prog_addr]      <= prog_op;
			mem_data[prog_addr]    <= prog_data;
			mem_delay[prog_addr]   <= prog_long ? prog_delay :
				{20'h00000, prog_delay[31:0]};
		end
	end

	// Pin synchronisers: change accepted when stages two and three agree
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			trig_sync_reg <= 3'h7;
			hrst_sync_reg <= 3'h7;
			trig_lvl_reg  <= 1'b0;
			hrst_lvl_reg  <= 1'b0;
		end else begin
			trig_sync_reg <= {trig_sync_reg[1:0], trig_n};
			hrst_sync_reg <= {hrst_sync_reg[1:0], hw_reset_n};
			if (trig_sync_reg[1] == trig_sync_reg[2])
				trig_lvl_reg <= ~trig_sync_reg[2];
			if (hrst_sync_reg[1] == hrst_sync_reg[2])
				hrst_lvl_reg <= ~hrst_sync_reg[2];
		end
	end

	// Current instruction decode
	wire [2:0]  cur_op      = mem_op[pc_reg];
	wire [19:0] cur_data    = mem_data[pc_reg];
	wire [11:0] pc_inc      = pc_reg + 12'h001;
	wire        dly_done    = (dly_reg == 52'h0000000000001);
	wire [3:0]  lsp_top     = lsp_reg - 4'h1;
	wire [3:0]  rsp_top     = rsp_reg - 4'h1;
	wire        loop_again  = (lsp_reg != 4'h0) &&
		(loop_cnt_reg[lsp_top[2:0]] > 20'h00001);
	// Loop start reached again from its own end: keep the open entry
	// rather than pushing a fresh one on every pass
	wire        loop_reenter = (lsp_reg != 4'h0) &&
		(loop_addr_reg[lsp_top[2:0]] == pc_reg);
	wire        stack_ok    = (rsp_reg < 4'h8);
	wire        loop_ok     = (lsp_reg < 4'h8);

	// Next address from flow-control operation
	logic [11:0] next_pc;
	always_comb begin
		next_pc = pc_inc;
		unique case (pps_op_t'(cur_op))
			PPS_OP_CONTINUE, PPS_OP_STOP, PPS_OP_WAIT, PPS_OP_LOOP:
				next_pc = pc_inc;
			PPS_OP_END_LOOP:
				next_pc = loop_again ? loop_addr_reg[lsp_top[2:0]] : pc_inc;
			PPS_OP_CALL, PPS_OP_BRANCH:
				next_pc = cur_data[11:0];
			PPS_OP_RETURN:
				next_pc = (rsp_reg != 4'h0) ?
					ret_stack_reg[rsp_top[2:0]] : pc_inc;
		endcase
	end

	// Sequencer state, pointer, delay timer and stacks
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= PPS_ST_IDLE;
			pc_reg    <= PPS_RESET_ADDR;
			dly_reg   <= 52'h0000000000000;
			lat_reg   <= 4'h0;
			rsp_reg   <= 4'h0;
			lsp_reg   <= 4'h0;
			out_reg   <= PPS_OUT_RESET;
		end else if (hrst_lvl_reg) begin
			state_reg <= PPS_ST_IDLE;
			pc_reg    <= PPS_RESET_ADDR;
			rsp_reg   <= 4'h0;
			lsp_reg   <= 4'h0;
			dly_reg   <= 52'h0000000000000;
		end else if (host_stop) begin
			state_reg <= PPS_ST_IDLE;
		end else begin
			unique case (state_reg)
				PPS_ST_IDLE: begin
					if (host_start || trig_lvl_reg) begin
						state_reg <= PPS_ST_RUN;
						out_reg   <= mem_pattern[pc_reg];
						dly_reg   <= clamp_delay(mem_delay[pc_reg]);
					end
				end
				PPS_ST_RUN: begin
					if (!dly_done) begin
						dly_reg <= dly_reg - 52'h0000000000001;
					end else begin
						pc_reg <= next_pc;
						if (pps_op_t'(cur_op) == PPS_OP_CALL && stack_ok) begin
							ret_stack_reg[rsp_reg[2:0]] <= pc_inc;
							rsp_reg <= rsp_reg + 4'h1;
						end
						if (pps_op_t'(cur_op) == PPS_OP_RETURN && rsp_reg != 4'h0)
							rsp_reg <= rsp_top;
						if (pps_op_t'(cur_op) == PPS_OP_LOOP && loop_ok
							&& !loop_reenter) begin
							loop_addr_reg[lsp_reg[2:0]] <= pc_reg;
							loop_cnt_reg[lsp_reg[2:0]]  <= cur_data;
							lsp_reg <= lsp_reg + 4'h1;
						end
						if (pps_op_t'(cur_op) == PPS_OP_END_LOOP) begin
							if (loop_again)
								loop_cnt_reg[lsp_top[2:0]] <=
									loop_cnt_reg[lsp_top[2:0]] - 20'h00001;
							else if (lsp_reg != 4'h0)
								lsp_reg <= lsp_top;
						end
						if (pps_op_t'(cur_op) == PPS_OP_STOP) begin
							state_reg <= PPS_ST_IDLE;
						end else if (pps_op_t'(cur_op) == PPS_OP_WAIT) begin
							state_reg <= PPS_ST_WAIT;
						end else begin
							out_reg <= mem_pattern[next_pc];
							dly_reg <= clamp_delay(mem_delay[next_pc]);
						end
					end
				end
				PPS_ST_WAIT: begin
					if (trig_lvl_reg || host_start) begin
						state_reg <= PPS_ST_ARM;
						lat_reg   <= PPS_TRIG_LATENCY - 4'h1;
					end
				end
				PPS_ST_ARM: begin
					if (lat_reg == 4'h1) begin
						state_reg <= PPS_ST_RUN;
						out_reg   <= mem_pattern[pc_reg];
						dly_reg   <= clamp_delay(mem_delay[pc_reg]);
					end else begin
						lat_reg <= lat_reg - 4'h1;
					end
				end
			endcase
		end
	end

	// Status outputs for pins and host polling
	assign chan_out     = out_reg;
	assign stat_running = (state_reg == PPS_ST_RUN);
	assign stat_waiting = (state_reg == PPS_ST_WAIT) ||
		(state_reg == PPS_ST_ARM);
	assign stat_stopped = (state_reg == PPS_ST_IDLE);

	// Assertions; the start edge itself changes the pattern
	a_min_delay_hold: assert property ($rose(stat_running) |=>
		!$changed(chan_out) [*4])
		else $error("instruction shorter than five cycles");
	a_trig_latency: assert property (
		disable iff (!resetn || hrst_lvl_reg || host_stop)
		(state_reg == PPS_ST_WAIT && trig_lvl_reg) |-> ##8 stat_running)
		else $error("trigger latency not eight cycles");
	a_hw_reset_pc: assert property (hrst_lvl_reg |=> (
		pc_reg == PPS_RESET_ADDR && rsp_reg == 4'h0
		&& lsp_reg == 4'h0 && stat_stopped))
		else $error("hardware reset did not clear pointer");
	a_stack_bound: assert property (
		rsp_reg <= 4'h8 && lsp_reg <= 4'h8)
		else $error("stack depth exceeds eight");
	a_delay_step: assert property (
		(stat_running && !dly_done && !hrst_lvl_reg && !host_stop)
		|=> dly_reg == $past(dly_reg) - 52'h0000000000001)
		else $error("delay not counting one per cycle");
	a_stop_cmd: assert property (host_stop |=> stat_stopped)
		else $error("stop command ignored");
	a_status_onehot: assert property (
		$onehot({stat_running, stat_waiting, stat_stopped}))
		else $error("status outputs inconsistent");
	a_start_run: assert property (
		(stat_stopped && host_start && !host_stop && !hrst_lvl_reg)
		|=> stat_running)
		else $error("start did not run");
	a_loop_reentry: assert property (
		(stat_running && dly_done && !hrst_lvl_reg && !host_stop
		&& pps_op_t'(cur_op) == PPS_OP_LOOP && loop_reenter)
		|=> $stable(lsp_reg))
		else $error("loop start pushed a second time");
	c_wait_resume: cover property (stat_waiting ##1 stat_running);
	c_call: cover property (rsp_reg == 4'h1);
	c_loop: cover property (lsp_reg == 4'h1);
endmodule
`default_nettype wire

//--- src/pps_pkg.sv
// Constants and types shared by the pulse program sequencer.
// Assumes a single 40 MHz core clock domain.
package pps_pkg;
	localparam int unsigned PPS_CHANNELS     = 24;
	localparam int unsigned PPS_DEPTH        = 4096;
	localparam int unsigned PPS_ADDR_W       = 12;
	localparam int unsigned PPS_DELAY_W      = 52;
	localparam int unsigned PPS_SHORT_W      = 32;
	localparam int unsigned PPS_DATA_W       = 20;
	localparam int unsigned PPS_STACK_DEPTH  = 8;
	localparam int unsigned PPS_SP_W         = 4;
	localparam int unsigned PPS_LOOP_W       = 20;
	// Shortest instruction duration, in clock periods
	localparam logic [51:0] PPS_MIN_DELAY    = 52'h0000000000005;
	// Cycles from trigger recognition to resumption
	localparam logic [3:0]  PPS_TRIG_LATENCY = 4'h8;
	localparam logic [11:0] PPS_RESET_ADDR   = 12'h000;
	localparam logic [23:0] PPS_OUT_RESET    = 24'h000000;
	// Flow-control opcodes
	typedef enum logic [2:0] {
		PPS_OP_CONTINUE = 3'b000,
		PPS_OP_STOP     = 3'b001,
		PPS_OP_LOOP     = 3'b010,
		PPS_OP_END_LOOP = 3'b011,
		PPS_OP_CALL     = 3'b100,
		PPS_OP_RETURN   = 3'b101,
		PPS_OP_BRANCH   = 3'b110,
		PPS_OP_WAIT     = 3'b111
	} pps_op_t;
	typedef enum logic [1:0] {
		PPS_ST_IDLE  = 2'b00,
		PPS_ST_RUN   = 2'b01,
		PPS_ST_WAIT  = 2'b10,
		PPS_ST_ARM   = 2'b11
	} pps_state_t;
endpackage

//--- tb/pps_ext_pins.sv
// Model of the external trigger and reset sources wired to the sequencer.
// Assumes the bench requests a line pulse with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module pps_ext_pins #(
	parameter int HOLD = 6
) (
	// Clock
	input  wire logic core_clk,
	// Requests from the bench
	input  wire logic trig_req,
	input  wire logic rst_req,
	// Open lines with pull-ups
	output logic      trig_n,
	output logic      hw_reset_n
);
	int trig_cnt = 0;
	int rst_cnt  = 0;
	// Hold each line at ground for HOLD cycles per request
	always @(posedge core_clk) begin
		if (trig_req) trig_cnt <= HOLD;
		else if (trig_cnt > 0) trig_cnt <= trig_cnt - 1;
		if (rst_req) rst_cnt <= HOLD;
		else if (rst_cnt > 0) rst_cnt <= rst_cnt - 1;
	end
	// Pulled to ground while asserted, pull-up otherwise
	assign trig_n     = (trig_cnt == 0);
	assign hw_reset_n = (rst_cnt == 0);
endmodule
`default_nettype wire

//--- tb/pulse_program_sequencer_test.sv
// Self-checking bench for the pulse program sequencer.
// Assumes the pin model drives trigger and reset; bench acts as host.
`timescale 1ns/1ps
`default_nettype none
module pulse_program_sequencer_test
	import pps_pkg::*;
;
	logic core_clk, resetn, prog_we, prog_long, host_start, host_stop;
	logic [11:0] prog_addr;
	logic [23:0] prog_pattern, chan_out;
	logic [2:0]  prog_op;
	logic [19:0] prog_data;
	logic [51:0] prog_delay;
	logic trig_req, rst_req, trig_n, hw_reset_n;
	logic stat_running, stat_waiting, stat_stopped;
	int errors = 0;
	int checks_done = 0;
	pps_sequencer i_pps_sequencer (.core_clk(core_clk), .resetn(resetn),
		.prog_we(prog_we), .prog_addr(prog_addr), .prog_pattern(prog_pattern),
		.prog_op(prog_op), .prog_data(prog_data), .prog_long(prog_long),
		.prog_delay(prog_delay), .host_start(host_start),
		.host_stop(host_stop), .trig_n(trig_n), .hw_reset_n(hw_reset_n),
		.chan_out(chan_out), .stat_running(stat_running),
		.stat_waiting(stat_waiting), .stat_stopped(stat_stopped));
	pps_ext_pins i_pps_ext_pins (.core_clk(core_clk), .trig_req(trig_req),
		.rst_req(rst_req), .trig_n(trig_n), .hw_reset_n(hw_reset_n));
	// Clock generation
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [51:0] got,
		input logic [51:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded wait for a status flag: 0 running, 1 waiting, 2 stopped
	task automatic await(input string what, input int which);
		logic s;
		int n;
		s = 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
			s = (which == 0) ? stat_running :
				(which == 1) ? stat_waiting : stat_stopped;
		end while (s !== 1'b1 && n < 40);
		check(what, {51'h0, s}, 52'h1);
		if (s !== 1'b1) give_verdict;
	endtask
	// Count cycles a pattern stays on the outputs
	task automatic hold(input logic [23:0] p, input int len);
		int n;
		n = 0;
		check("pattern", {28'h0, chan_out}, {28'h0, p});
		while (chan_out === p && n < 40) begin
			n++;
			@(negedge core_clk);
		end
		check("duration", 52'(n), 52'(len));
		if (n == 40) give_verdict;
	endtask
	task automatic wr(input logic [11:0] a, input logic [23:0] p,
		input logic [2:0] op, input logic [19:0] d, input logic [51:0] dl);
		@(posedge core_clk);
		prog_we <= 1'b1;
		prog_addr <= a;
		prog_pattern <= p;
		prog_op <= op;
		prog_data <= d;
		prog_delay <= dl;
		@(posedge core_clk);
		prog_we <= 1'b0;
	endtask
	// One-cycle request, one-hot: start, stop, trigger, reset
	task automatic pulse(input logic [3:0] sel);
		@(posedge core_clk);
		{host_start, host_stop, trig_req, rst_req} <= sel;
		@(posedge core_clk);
		{host_start, host_stop, trig_req, rst_req} <= 4'h0;
	endtask
	task automatic t_reset;
		@(negedge core_clk);
		check("chan_out", {28'h0, chan_out}, 52'h0);
		check("stopped", {51'h0, stat_stopped}, 52'h1);
		$display("test reset done");
	endtask
	task automatic t_run;
		int n;
		wr(12'h000, 24'h000001, PPS_OP_CONTINUE, 20'h0, 52'h6);
		wr(12'h001, 24'h800002, PPS_OP_CONTINUE, 20'h0, 52'h2);
		wr(12'h002, 24'h0a0003, PPS_OP_CONTINUE, 20'h0, 52'h10000000007);
		wr(12'h003, 24'h000004, PPS_OP_LOOP, 20'h3, 52'h5);
		wr(12'h004, 24'h000005, PPS_OP_END_LOOP, 20'h3, 52'h5);
		wr(12'h005, 24'h000006, PPS_OP_CALL, 20'h00a, 52'h5);
		wr(12'h006, 24'h000007, PPS_OP_WAIT, 20'h0, 52'h5);
		wr(12'h007, 24'h000008, PPS_OP_STOP, 20'h0, 52'h5);
		wr(12'h00a, 24'hfff00a, PPS_OP_RETURN, 20'h0, 52'h5);
		pulse(4'h8);
		await("running", 0);
		hold(24'h000001, 6);
		hold(24'h800002, 5);
		hold(24'h0a0003, 7);
		for (int i = 0; i < 3; i++) begin
			hold(24'h000004, 5);
			hold(24'h000005, 5);
		end
		hold(24'h000006, 5);
		hold(24'hfff00a, 5);
		check("wait pattern", {28'h0, chan_out}, 52'h7);
		await("waiting", 1);
		pulse(4'h2);
		// Wait for the pin model to pull the trigger line low
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (trig_n !== 1'b0 && n < 40);
		check("trigger pin", {51'h0, trig_n}, 52'h0);
		if (trig_n !== 1'b0) give_verdict;
		n = 0;
		while (stat_running !== 1'b1 && n < 40) begin
			n++;
			@(negedge core_clk);
		end
		check("latency", {51'h0, n >= 8 && n <= 14}, 52'h1);
		if (stat_running !== 1'b1) give_verdict;
		check("resumed", {28'h0, chan_out}, 52'h8);
		await("stopped", 2);
		$display("test run done");
	endtask
	task automatic t_hwreset;
		int n;
		// Word after the stop so the restart runs defined contents
		wr(12'h008, 24'h000009, PPS_OP_CONTINUE, 20'h0, 52'h40);
		pulse(4'h8);
		await("restart", 0);
		check("restart word", {28'h0, chan_out}, 52'h9);
		repeat (9) @(negedge core_clk);
		pulse(4'h1);
		await("reset stops", 2);
		// Reset line must be back high before a trigger can start
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (hw_reset_n !== 1'b1 && n < 40);
		check("reset pin", {51'h0, hw_reset_n}, 52'h1);
		if (hw_reset_n !== 1'b1) give_verdict;
		repeat (6) @(negedge core_clk);
		pulse(4'h2);
		await("trigger start", 0);
		check("first word", {28'h0, chan_out}, 52'h1);
		pulse(4'h4);
		await("host stop", 2);
		$display("test hardware reset done");
	endtask
	// Cut a hung run short
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		give_verdict;
	end
	initial begin
		resetn = 1'b0;
		{prog_we, prog_long, host_start, host_stop, trig_req, rst_req} = '0;
		prog_addr = 12'h000;
		prog_pattern = 24'h000000;
		prog_op = 3'h0;
		prog_data = 20'h00000;
		prog_delay = 52'h0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset;
		t_run;
		t_hwreset;
		give_verdict;
	end
endmodule
`default_nettype wire
